/* core/cpd_core.sv */
// Functional notes
// - watchdog runs unless the strap disables it; software cannot stop it
// - watchdog counts ticks of its own oscillator pin, not the core clock
// - reset delay timer holds the core about 18 ms after any reset
// - sleep is left only by external reset or watchdog time-out
// - or/and/xor with file use 0001 00df/01df/10df, one cycle, zero flag
// - decrement/increment skip write result, skip if zero, no flags
// - rotates shift through carry, one cycle, only carry changes
// - bit tests 0110/0111 skip when bit clear/set, one or two cycles
// - return with literal pops return address, loads W, two cycles
// - branch and call take two cycles and change no flags
// - sleep opcode enters standby and updates time-out and power-down bits
// - watchdog clear opcode clears counter, updates time-out and power-down
// - option opcode copies W to option register in one cycle
// - literal or/and/xor combine literal with W, only zero flag
// - call and pcl writes force pc bit 8 to zero; branch and return do not
// - read-modify-write of a port reads the pin levels
// - direction load with 5, 6, 7 copies W to port a, b, c latches
// - direction bit one turns the pin driver off
// - any write to the timer register clears prescaler when timer owns it
// - watchdog clear also clears the prescaler when watchdog owns it
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cpd_core
  import cpd_pkg::*;
#(
  parameter int DRT_CYCLES = cpd_pkg::DRT_CYCLES,
  parameter int WDT_BASE_W = cpd_pkg::WDT_BASE_BITS,
  parameter int PC_W       = cpd_pkg::PC_BITS
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic      [PC_W-1:0] pmem_addr,
  input  wire logic [11:0]     pmem_data,
  input  wire logic            watchdog_enable_config,
  input  wire logic            wdt_osc,
  input  wire logic [7:0]      port_a_a_in,
  output logic      [7:0]      port_a_a_out,
  output logic      [7:0]      port_a_a_oe,
  input  wire logic [7:0]      port_b_b_in,
  output logic      [7:0]      port_b_b_out,
  output logic      [7:0]      port_b_b_oe,
  input  wire logic [7:0]      port_c_c_in,
  output logic      [7:0]      port_c_c_out,
  output logic      [7:0]      port_c_c_oe
);
  import cpd_pkg::*;

  localparam int DRT_W = $clog2(DRT_CYCLES);

  typedef struct packed {
    cpd_mode_e            mode;
    logic [1:0]           q;
    logic                 run;
    logic                 wdt_en;
    logic                 wdt_taken;
    logic [DRT_W-1:0]     reset_delay_timer;
    logic [WDT_BASE_W-1:0] wdt;
    logic [7:0]           pre;
    logic [11:0]          ir;
    logic [PC_W-1:0]      pc;
    logic [PC_W-1:0]      stk0;
    logic [PC_W-1:0]      stk1;
    logic [7:0]           w;
    logic [5:0]           opt;
    logic [7:0]           direction_latch_load_a;
    logic [7:0]           direction_latch_load_b;
    logic [7:0]           direction_latch_load_c;
    logic [31:0][7:0]     ram;
    logic [31:0]          prdata;
  } cpd_state_s;

  cpd_state_s       state_reg;
  cpd_state_s       state_next;
  logic [23:0]      pins;
  logic [0:0]       osc_rise;
  logic [4:0]       ea;
  logic             ce;
  logic             exec;
  logic [7:0]       fval;
  logic [7:0]       res;
  logic [7:0]       bmask;
  logic [7:0]       pmask;
  logic [8:0]       sum9;
  logic [4:0]       dc5;
  logic [31:0]      rdw;
  logic             wr_w;
  logic             wr_f;
  logic             upd_z;
  logic             upd_c;
  logic             upd_dc;
  logic             c_val;
  logic             skip;
  logic             jump;
  logic             wdt_timeout;
  logic             mapped;

  cpd_sync #(
    .W (24)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({port_c_c_in, port_b_b_in, port_a_a_in}),
    .level    (pins),
    .rise     ()
  );

  // the watchdog oscillator is only sampled, so it must be slower than pclk / 2
  cpd_sync #(
    .W (1)
  ) u_osc_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (wdt_osc),
    .level    (),
    .rise     (osc_rise)
  );

  assign ce     = (state_reg.q == Q_LAST);
  assign exec   = ce && state_reg.run && (state_reg.mode == MODE_RUN);
  assign ea     = (state_reg.ir[4:0] == F_INDIRECT) ? state_reg.ram[F_FSR][4:0]
                                                    : state_reg.ir[4:0];
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_CORE);

  always_comb begin
    state_next   = state_reg;
    state_next.q = state_reg.q + 2'h1;
    res          = 8'h00;
    sum9         = 9'h000;
    dc5          = 5'h00;
    rdw          = 32'h0000_0000;
    wr_w         = 1'b0;
    wr_f         = 1'b0;
    upd_z        = 1'b0;
    upd_c        = 1'b0;
    upd_dc       = 1'b0;
    c_val        = 1'b0;
    skip         = 1'b0;
    jump         = 1'b0;
    wdt_timeout  = 1'b0;
    bmask        = 8'h01 << state_reg.ir[7:5];
    pmask        = 8'((9'h002 << state_reg.opt[2:0]) - 9'h001);

    // strap is caught once, at the first edge after reset release
    if (!state_reg.wdt_taken) begin
      state_next.wdt_en    = watchdog_enable_config;
      state_next.wdt_taken = 1'b1;
    end

    case (ea)
      F_INDIRECT: fval = 8'h00;
      F_PCL:      fval = state_reg.pc[7:0];
      F_FSR:      fval = {FSR_FILL, state_reg.ram[F_FSR][4:0]};
      F_PORT_A:   fval = pins[7:0];
      F_PORT_B:   fval = pins[15:8];
      F_PORT_C:   fval = pins[23:16];
      default:    fval = state_reg.ram[ea];
    endcase

    case (state_reg.mode)
      MODE_DELAY: begin
        state_next.wdt = '0;
        state_next.reset_delay_timer = state_reg.reset_delay_timer + DRT_W'(1);
        if (state_reg.reset_delay_timer == DRT_W'(DRT_CYCLES - 1)) begin
          state_next.reset_delay_timer  = '0;
          state_next.mode = MODE_RUN;
        end
      end
      MODE_RUN:   ;
      MODE_SLEEP: ;
      default:    state_next.mode = MODE_DELAY;
    endcase

    // timer runs from the instruction clock, which stops in sleep
    if (exec) begin
      if (state_reg.opt[OPT_PSA]) begin
        state_next.ram[F_TIMER] = state_reg.ram[F_TIMER] + 8'h01;
      end else begin
        state_next.pre = state_reg.pre + 8'h01;
        if ((state_reg.pre & pmask) == pmask) begin
          state_next.ram[F_TIMER] = state_reg.ram[F_TIMER] + 8'h01;
        end
      end
    end

    if (state_reg.wdt_en && osc_rise[0] && (state_reg.mode != MODE_DELAY)) begin
      state_next.wdt = state_reg.wdt + WDT_BASE_W'(1);
      if (&state_reg.wdt) begin
        if (state_reg.opt[OPT_PSA]) begin
          state_next.pre = state_reg.pre + 8'h01;
          wdt_timeout    = ((state_reg.pre & pmask) == pmask);
        end else begin
          wdt_timeout = 1'b1;
        end
      end
    end

    if (exec) begin
      state_next.ir = pmem_data;
      state_next.pc = state_reg.pc + PC_W'(1);
      case (state_reg.ir[11:10])
        2'b00: begin
          if (state_reg.ir[11:5] == 7'h00) begin
            case (state_reg.ir[4:0])
              MISC_OPTION: state_next.opt = state_reg.w[5:0];
              MISC_SLEEP: begin
                state_next.mode                 = MODE_SLEEP;
                state_next.ram[F_STATUS][ST_TO] = 1'b1;
                state_next.ram[F_STATUS][ST_PD] = 1'b0;
                state_next.wdt                  = '0;
                if (state_reg.opt[OPT_PSA]) begin
                  state_next.pre = 8'h00;
                end
              end
              MISC_WATCHDOG_CLEAR_OP: begin
                state_next.wdt                  = '0;
                state_next.ram[F_STATUS][ST_TO] = 1'b1;
                state_next.ram[F_STATUS][ST_PD] = 1'b1;
                if (state_reg.opt[OPT_PSA]) begin
                  state_next.pre = 8'h00;
                end
              end
              MISC_DIRECTION_LATCH_LOAD_A: state_next.direction_latch_load_a = state_reg.w;
              MISC_DIRECTION_LATCH_LOAD_B: state_next.direction_latch_load_b = state_reg.w;
              MISC_DIRECTION_LATCH_LOAD_C: state_next.direction_latch_load_c = state_reg.w;
              default:     ;
            endcase
          end else begin
            wr_f = state_reg.ir[5];
            wr_w = !state_reg.ir[5];
            case (state_reg.ir[9:6])
              4'h0: res = state_reg.w;
              4'h1: begin
                res   = 8'h00;
                upd_z = 1'b1;
              end
              4'h2: begin
                sum9   = {1'b0, fval} + {1'b0, ~state_reg.w} + 9'h001;
                dc5    = {1'b0, fval[3:0]} + {1'b0, ~state_reg.w[3:0]} + 5'h01;
                res    = sum9[7:0];
                c_val  = sum9[8];
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
              end
              4'h3: begin
                res   = fval - 8'h01;
                upd_z = 1'b1;
              end
              4'h4: begin
                res   = fval | state_reg.w;
                upd_z = 1'b1;
              end
              4'h5: begin
                res   = fval & state_reg.w;
                upd_z = 1'b1;
              end
              4'h6: begin
                res   = fval ^ state_reg.w;
                upd_z = 1'b1;
              end
              4'h7: begin
                sum9   = {1'b0, fval} + {1'b0, state_reg.w};
                dc5    = {1'b0, fval[3:0]} + {1'b0, state_reg.w[3:0]};
                res    = sum9[7:0];
                c_val  = sum9[8];
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
              end
              4'h8: begin
                res   = fval;
                upd_z = 1'b1;
              end
              4'h9: begin
                res   = ~fval;
                upd_z = 1'b1;
              end
              4'hA: begin
                res   = fval + 8'h01;
                upd_z = 1'b1;
              end
              4'hB: begin
                res  = fval - 8'h01;
                skip = (res == 8'h00);
              end
              4'hC: begin
                res   = {state_reg.ram[F_STATUS][ST_C], fval[7:1]};
                c_val = fval[0];
                upd_c = 1'b1;
              end
              4'hD: begin
                res   = {fval[6:0], state_reg.ram[F_STATUS][ST_C]};
                c_val = fval[7];
                upd_c = 1'b1;
              end
              4'hE: res = {fval[3:0], fval[7:4]};
              default: begin
                res  = fval + 8'h01;
                skip = (res == 8'h00);
              end
            endcase
          end
        end
        2'b01: begin
          case (state_reg.ir[9:8])
            2'b00: begin
              res  = fval & ~bmask;
              wr_f = 1'b1;
            end
            2'b01: begin
              res  = fval | bmask;
              wr_f = 1'b1;
            end
            2'b10:   skip = ((fval & bmask) == 8'h00);
            default: skip = ((fval & bmask) != 8'h00);
          endcase
        end
        default: begin
          case (state_reg.ir[11:8])
            OP_RETURN_LITERAL_OP: begin
              state_next.w    = state_reg.ir[7:0];
              state_next.pc   = state_reg.stk0;
              state_next.stk0 = state_reg.stk1;
              jump            = 1'b1;
            end
            OP_CALL: begin
              state_next.stk1 = state_reg.stk0;
              state_next.stk0 = state_reg.pc;
              state_next.pc   = PC_W'({1'b0, state_reg.ir[7:0]});
              jump            = 1'b1;
            end
            OP_GOTO0, OP_GOTO1: begin
              state_next.pc = PC_W'(state_reg.ir[8:0]);
              jump          = 1'b1;
            end
            OP_MOVLW: state_next.w = state_reg.ir[7:0];
            OP_OR_LITERAL_OP: begin
              res   = state_reg.w | state_reg.ir[7:0];
              wr_w  = 1'b1;
              upd_z = 1'b1;
            end
            OP_AND_LITERAL_OP: begin
              res   = state_reg.w & state_reg.ir[7:0];
              wr_w  = 1'b1;
              upd_z = 1'b1;
            end
            default: begin
              res   = state_reg.w ^ state_reg.ir[7:0];
              wr_w  = 1'b1;
              upd_z = 1'b1;
            end
          endcase
        end
      endcase

      if (wr_w) begin
        state_next.w = res;
      end
      if (wr_f) begin
        case (ea)
          F_INDIRECT: ;
          F_TIMER: begin
            state_next.ram[F_TIMER] = res;
            if (!state_reg.opt[OPT_PSA]) begin
              state_next.pre = 8'h00;
            end
          end
          F_PCL: begin
            state_next.pc = PC_W'({1'b0, res});
            jump          = 1'b1;
          end
          // power-down and time-out bits are not writable
          F_STATUS: begin
            state_next.ram[F_STATUS][7:5] = res[7:5];
            state_next.ram[F_STATUS][2:0] = res[2:0];
          end
          default: state_next.ram[ea] = res;
        endcase
      end
      if (upd_z) begin
        state_next.ram[F_STATUS][ST_Z] = (res == 8'h00);
      end
      if (upd_c) begin
        state_next.ram[F_STATUS][ST_C] = c_val;
      end
      if (upd_dc) begin
        state_next.ram[F_STATUS][ST_DC] = dc5[4];
      end
      // the fetched word is already in flight, so it is replaced by a nop
      if (skip || jump) begin
        state_next.ir = INSN_NOP;
      end
    end

    if (wdt_timeout) begin
      state_next.mode                 = MODE_DELAY;
      state_next.reset_delay_timer                  = '0;
      state_next.wdt                  = '0;
      state_next.pre                  = 8'h00;
      state_next.pc                   = '1;
      state_next.ir                   = INSN_NOP;
      state_next.opt                  = OPTION_RST;
      state_next.direction_latch_load_a               = DIRECTION_LATCH_LOAD_RST;
      state_next.direction_latch_load_b               = DIRECTION_LATCH_LOAD_RST;
      state_next.direction_latch_load_c               = DIRECTION_LATCH_LOAD_RST;
      state_next.ram[F_STATUS][ST_TO] = 1'b0;
      state_next.ram[F_STATUS][ST_PD] = (state_reg.mode != MODE_SLEEP);
    end

    rdw[PC_W-1:0]                = state_reg.pc;
    rdw[STAT_MODE_LSB +: 2]      = state_reg.mode;
    rdw[STAT_WDTEN_BIT]          = state_reg.wdt_en;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: state_next.prdata = {31'h0000_0000, state_reg.run};
        REG_STAT: state_next.prdata = rdw;
        REG_CORE: state_next.prdata = {10'h000, state_reg.opt, state_reg.w,
                                       state_reg.ram[F_STATUS]};
        default:  state_next.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && (paddr == REG_CTRL)) begin
      state_next.run = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                <= '0;
      state_reg.mode           <= MODE_DELAY;
      state_reg.run            <= CTRL_RUN_RST;
      state_reg.pc             <= '1;
      state_reg.opt            <= OPTION_RST;
      state_reg.direction_latch_load_a         <= DIRECTION_LATCH_LOAD_RST;
      state_reg.direction_latch_load_b         <= DIRECTION_LATCH_LOAD_RST;
      state_reg.direction_latch_load_c         <= DIRECTION_LATCH_LOAD_RST;
      state_reg.ram[F_STATUS]  <= STATUS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata       = state_reg.prdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign pmem_addr    = state_reg.pc;
  assign port_a_a_out = state_reg.ram[F_PORT_A];
  assign port_b_b_out = state_reg.ram[F_PORT_B];
  assign port_c_c_out = state_reg.ram[F_PORT_C];
  assign port_a_a_oe  = ~state_reg.direction_latch_load_a;
  assign port_b_b_oe  = ~state_reg.direction_latch_load_b;
  assign port_c_c_oe  = ~state_reg.direction_latch_load_c;

endmodule
`default_nettype wire

/* core/cpd_pkg.sv */
package cpd_pkg;

  localparam int CLK_MHZ       = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DRT_TIME_US   = 18000;
  localparam int DRT_CYCLES    = DRT_TIME_US * CLK_MHZ;

  // four clock phases make one instruction cycle
  localparam logic [1:0] Q_LAST = 2'h3;

  localparam int WDT_BASE_BITS = 8;
  localparam int PC_BITS       = 9;

  typedef enum logic [1:0] {
    MODE_DELAY,
    MODE_RUN,
    MODE_SLEEP
  } cpd_mode_e;

  // file register map
  localparam logic [4:0] F_INDIRECT = 5'h00;
  localparam logic [4:0] F_TIMER    = 5'h01;
  localparam logic [4:0] F_PCL      = 5'h02;
  localparam logic [4:0] F_STATUS   = 5'h03;
  localparam logic [4:0] F_FSR      = 5'h04;
  localparam logic [4:0] F_PORT_A   = 5'h05;
  localparam logic [4:0] F_PORT_B   = 5'h06;
  localparam logic [4:0] F_PORT_C   = 5'h07;

  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;

  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [5:0] OPTION_RST = 6'h3F;
  localparam int         OPT_PSA    = 3;
  localparam logic [7:0] DIRECTION_LATCH_LOAD_RST   = 8'hFF;
  localparam logic [2:0] FSR_FILL   = 3'h7;

  localparam logic [11:0] INSN_NOP = 12'h000;
  localparam logic [4:0]  MISC_OPTION = 5'h02;
  localparam logic [4:0]  MISC_SLEEP  = 5'h03;
  localparam logic [4:0]  MISC_WATCHDOG_CLEAR_OP = 5'h04;
  localparam logic [4:0]  MISC_DIRECTION_LATCH_LOAD_A = 5'h05;
  localparam logic [4:0]  MISC_DIRECTION_LATCH_LOAD_B = 5'h06;
  localparam logic [4:0]  MISC_DIRECTION_LATCH_LOAD_C = 5'h07;

  localparam logic [3:0] OP_RETURN_LITERAL_OP = 4'h8;
  localparam logic [3:0] OP_CALL  = 4'h9;
  localparam logic [3:0] OP_GOTO0 = 4'hA;
  localparam logic [3:0] OP_GOTO1 = 4'hB;
  localparam logic [3:0] OP_MOVLW = 4'hC;
  localparam logic [3:0] OP_OR_LITERAL_OP = 4'hD;
  localparam logic [3:0] OP_AND_LITERAL_OP = 4'hE;
  localparam logic [3:0] OP_XOR_LITERAL_OP = 4'hF;

  // apb register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_CORE = 12'h008;
  localparam logic        CTRL_RUN_RST   = 1'b1;
  localparam int          STAT_MODE_LSB  = 16;
  localparam int          STAT_WDTEN_BIT = 18;
  localparam int          CORE_W_LSB     = 8;
  localparam int          CORE_OPT_LSB   = 16;

endpackage

/* core/cpd_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module cpd_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } cpd_sync_s;

  cpd_sync_s sync_reg;
  cpd_sync_s sync_next;

  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = async_in;
    sync_next.lvl  = sync_reg.meta;
    sync_next.prev = sync_reg.lvl;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.lvl;
  assign rise  = sync_reg.lvl & ~sync_reg.prev;

endmodule
`default_nettype wire

/* dv/cpd_core_props.sv */
`timescale 1ns/100ps
`default_nettype none
module cpd_core_props
  import cpd_pkg::*;
#(
  parameter int DRT_CYCLES = 20,
  parameter int PC_W       = 9
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic [7:0]      port_a_a_out,
  input wire logic [7:0]      port_b_b_oe
);
  logic [31:0] rel_cnt;
  logic        mapped;
  assign mapped = paddr inside {REG_CTRL, REG_STAT, REG_CORE};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rel_cnt <= '0;
    else if (rel_cnt < DRT_CYCLES) rel_cnt <= rel_cnt + 32'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_err_unmapped; psel && penable && !mapped |-> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");
  property p_err_mapped; pslverr |-> psel && penable && !mapped; endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("error outside unmapped access");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_rdata_hold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside setup");
  property p_delay_hold; rel_cnt < DRT_CYCLES |-> &pmem_addr; endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("fetch during reset delay");
  property p_cycle_len; $changed(pmem_addr) |=> $stable(pmem_addr) [*3]; endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("fetch address moved mid cycle");
  property p_oe_on_cycle; $changed(port_b_b_oe) |-> $changed(pmem_addr); endproperty
  a_oe_on_cycle: assert property (p_oe_on_cycle) else $error("driver enable off cycle");
  property p_out_on_cycle; $changed(port_a_a_out) |-> $changed(pmem_addr); endproperty
  a_out_on_cycle: assert property (p_out_on_cycle) else $error("port latch off cycle");
  c_unmapped: cover property (psel && penable && pslverr);
  c_oe_drop: cover property ($fell(port_b_b_oe[7]));
  c_out_set: cover property ($rose(port_a_a_out[0]));
endmodule
bind cpd_core cpd_core_props #(.DRT_CYCLES(DRT_CYCLES), .PC_W(PC_W)) i_cpd_core_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr),
  .port_a_a_out(port_a_a_out), .port_b_b_oe(port_b_b_oe));
`default_nettype wire

/* dv/cpd_core_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module cpd_core_test;
  import cpd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        wdt_osc, osc_on, wden;
  logic [2:0]  div;
  logic [11:0] paddr, pmem_data;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  pmem_addr;
  logic [7:0]  pa_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
  logic [11:0] rom [0:511];
  // word 30 is the subroutine reached by the call at word 21
  logic [11:0] prog [31] = '{12'hC0F, 12'h006, 12'hCFF, 12'h025, 12'hC01, 12'h125,
    12'h028, 12'h2E8, 12'hC77, 12'h007, 12'hC81, 12'h029, 12'h369, 12'h5E9, 12'h429,
    12'h6E9, 12'h2A9, 12'h7E9, 12'h2A9, 12'h209, 12'h026, 12'h91E, 12'h027, 12'hCA5,
    12'hFA5, 12'hD3C, 12'hE0C, 12'h002, 12'h003, 12'h000, 12'h85A};
  int          mismatches, compares, n;
  cpd_core #(.DRT_CYCLES(40), .WDT_BASE_W(3)) i_cpd_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data), .watchdog_enable_config(wden),
    .wdt_osc(wdt_osc), .port_a_a_in(pa_in), .port_a_a_out(pa_out), .port_a_a_oe(pa_oe),
    .port_b_b_in(8'h00), .port_b_b_out(pb_out), .port_b_b_oe(pb_oe),
    .port_c_c_in(8'h00), .port_c_c_out(pc_out), .port_c_c_oe(pc_oe));
  always #20 pclk = ~pclk;
  always @(posedge pclk) pmem_data <= rom[pmem_addr];
  // slow osc only while waiting in standby, so no time-out disturbs the program
  always @(posedge pclk) begin
    if (osc_on) begin
      div <= (div == 3'h2) ? 3'h0 : div + 3'h1;
      if (div == 3'h2) wdt_osc <= ~wdt_osc;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input logic sleeping);
    n = 0;
    do begin
      apb(1'b0, REG_STAT);
      n++;
    end while (((rd[17:16] === 2'h2) != sleeping) && n < 3000);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, wdt_osc, osc_on, div} = '0;
    {paddr, pwdata, pmem_data, mismatches, compares} = '0;
    pa_in = 8'h3C;
    wden = 1'b1;
    for (n = 0; n < 512; n++) rom[n] = 12'hA10;
    for (n = 0; n < 31; n++) rom[n] = prog[n];
    rom[511] = 12'hA00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL);
    `CHK(rd[0], CTRL_RUN_RST)
    apb(1'b0, REG_STAT);
    `CHK(rd, 32'h000401FF)
    apb(1'b1, 12'h00C);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h00C);
    `CHK(rd, 32'h0)
    wait_mode(1'b1);
    `CHK(rd[17:16], 2'h2)
    apb(1'b0, REG_CORE);
    `CHK(rd, 32'h000C0C11)
    `CHK(rd[0], 1'b1)
    `CHK(pb_out, 8'h81)
    `CHK(pc_out, 8'h5A)
    `CHK(pa_out, 8'h3D)
    `CHK(pb_oe, 8'hF0)
    `CHK(pc_oe, 8'hFE)
    `CHK(pa_oe, 8'h00)
    repeat (200) @(posedge pclk);
    apb(1'b0, REG_STAT);
    `CHK(rd[17:16], 2'h2)
    osc_on <= 1'b1;
    wait_mode(1'b0);
    osc_on <= 1'b0;
    `CHK(rd[17:16] !== 2'h2, 1'b1)
    apb(1'b0, REG_CORE);
    `CHK(rd[4:3], 2'h0)
    `CHK(pb_oe, 8'h00)
    // second reset with the strap off: standby must never be left
    wden <= 1'b0;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT);
    `CHK(rd, 32'h000001FF)
    wait_mode(1'b1);
    osc_on <= 1'b1;
    wait_mode(1'b0);
    `CHK(rd[17:16], 2'h2)
    apb(1'b1, REG_CTRL);
    `CHK(err, 1'b0)
    apb(1'b0, REG_CTRL);
    `CHK(rd[0], 1'b0)
    print_verdict;
  end
endmodule
`default_nettype wire
